// *** rtl/dac_input_latch_consts.svh ***
// Purpose: Constants for the converter input latch front end
// Assumes: Included by bare name from design files
// Notes: Definitions only
`ifndef DAC_INPUT_LATCH_CONSTS_SVH
`define DAC_INPUT_LATCH_CONSTS_SVH

// Sample word width and bit positions
`define SAMPLE_WIDTH 10
`define SAMPLE_LSB_POS 0
`define SAMPLE_MSB_POS 9

// Reset values of the pipeline stages
`define SAMPLE_RESET_VALUE 10'h000

// Reset values of the status outputs: core running on the bandgap
`define CORE_ENABLE_RESET_VALUE 1'h1
`define STANDBY_ACTIVE_RESET_VALUE 1'h0
`define INTERNAL_REF_RESET_VALUE 1'h1
`define REF_PIN_INPUT_RESET_VALUE 1'h0

// Bandgap reference figure in millivolts, for information
`define BANDGAP_MILLIVOLTS 1240

// Clock period in ns
`define CLK_PERIOD_NS 8

`endif

// *** rtl/dac_input_latch_pkg.sv ***
// Purpose: Types for the converter input latch front end
// Assumes: Constants come from the header
// Notes: No import; refer as package::name
`include "dac_input_latch_consts.svh"

package dac_input_latch_pkg;

    // Straight binary sample word
    typedef logic [`SAMPLE_WIDTH-1:0] sample_t;

    // Operating mode of the converter
    typedef enum logic [0:0] {
        MODE_RUN,
        MODE_STANDBY
    } power_mode_t;

    // Reference source selection
    typedef enum logic [0:0] {
        REF_INTERNAL,
        REF_EXTERNAL
    } ref_source_t;

endpackage

// *** rtl/dac_input_latch_powerdown.sv ***
// Purpose: Digital front end of a 10-bit current-output converter
// Assumes: Inputs synchronous to clk, source keeps straight binary
// Notes: Two stages give one cycle from capture to core update
`timescale 1ns/10ps
`include "dac_input_latch_consts.svh"

module dac_input_latch_powerdown
(
    input wire logic clk,
    input wire logic nrst,
    input wire dac_input_latch_pkg::sample_t sampleIn,
    input wire logic standbyRequestPin,
    input wire logic standbyRequestPinDriven,
    input wire logic refSelectPin,
    output dac_input_latch_pkg::sample_t coreWord,
    output logic coreEnable,
    output logic standbyActive,
    output logic internalRefEnable,
    output logic referenceVoltagePinIsInput
);

    ////////////////////////////////////////////////////////////////////
    // Control decode

    // Effective standby level after the internal pull-down
    logic standbyLevel;
    // Stage load enable, shared by both stages
    logic stageLoad;
    // Master stage output
    dac_input_latch_pkg::sample_t masterWord;
    // Slave stage output feeding the core
    dac_input_latch_pkg::sample_t slaveWord;

    // Floating pin resolves low through the pull-down
    always_comb
    begin
        standbyLevel = 1'b0;
        if (standbyRequestPinDriven)
        begin
            standbyLevel = standbyRequestPin;
        end
    end

    // Load every edge while running, hold while in standby
    // One shared load keeps master and slave in step, so no word
    // skips the slave or is doubled when standby ends
    always_comb
    begin
        stageLoad = !standbyLevel;
    end

    ////////////////////////////////////////////////////////////////////
    // Input word assembly

    // Word as handed to the master stage
    dac_input_latch_pkg::sample_t sampleWord;

    // Each pin bit keeps its binary weight, lowest weight at bit zero
    // and highest at the top bit: no reordering and no inversion
    generate
        for (genvar bitIdx = `SAMPLE_LSB_POS; bitIdx <= `SAMPLE_MSB_POS;
            bitIdx = bitIdx + 1)
        begin : gBitOrder
            assign sampleWord[bitIdx] = sampleIn[bitIdx];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Sample path
    // Two edge-triggered stages form the master-slave latch
    // Reset clears both stages so the core starts at zero scale

    // Master stage: captures the input word each edge while running, holds in standby
    sample_stage masterStage
    (
        .clk(clk),
        .nrst(nrst),
        .load(stageLoad),
        .dataIn(sampleWord),
        .dataOut(masterWord)
    );

    // Slave stage: hands the word to the core one edge later
    sample_stage slaveStage
    (
        .clk(clk),
        .nrst(nrst),
        .load(stageLoad),
        .dataIn(masterWord),
        .dataOut(slaveWord)
    );

    assign coreWord = slaveWord;

    ////////////////////////////////////////////////////////////////////
    // Power mode group

    // Mode chosen by the resolved standby level this cycle
    dac_input_latch_pkg::power_mode_t modeSel;
    // Core enable output flop and its next value
    logic coreEnable_reg;
    logic coreEnable_next;
    // Standby status output flop and its next value
    logic standbyActive_reg;
    logic standbyActive_next;

    // Next power outputs; they follow the standby pin one edge later
    always_comb
    begin
        // Running unless standby is asked for
        modeSel = dac_input_latch_pkg::MODE_RUN;
        if (standbyLevel)
        begin
            modeSel = dac_input_latch_pkg::MODE_STANDBY;
        end
        unique case (modeSel)
            // Normal operation: core converts
            dac_input_latch_pkg::MODE_RUN:
            begin
                coreEnable_next = 1'b1;
                standbyActive_next = 1'b0;
            end
            // Low-power standby: core stopped
            dac_input_latch_pkg::MODE_STANDBY:
            begin
                coreEnable_next = 1'b0;
                standbyActive_next = 1'b1;
            end
        endcase
    end

    // Register the power outputs; reset leaves the core running
    // Enable and status flip together, so they never agree
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            coreEnable_reg <= `CORE_ENABLE_RESET_VALUE;
            standbyActive_reg <= `STANDBY_ACTIVE_RESET_VALUE;
        end
        else
        begin
            coreEnable_reg <= coreEnable_next;
            standbyActive_reg <= standbyActive_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reference group

    // Reference source chosen by the select pin this cycle
    dac_input_latch_pkg::ref_source_t refSel;
    // Internal reference enable output flop and its next value
    logic internalRef_reg;
    logic internalRef_next;
    // Reference pin direction output flop and its next value
    logic refPinInput_reg;
    logic refPinInput_next;

    // Next reference outputs; the select is a static strap, so it
    // needs no filtering, and a change simply shows one edge later
    always_comb
    begin
        // Grounded select keeps the on-chip bandgap in use
        refSel = dac_input_latch_pkg::REF_INTERNAL;
        if (refSelectPin)
        begin
            refSel = dac_input_latch_pkg::REF_EXTERNAL;
        end
        unique case (refSel)
            // Bandgap on, reference pin not taken as an input
            dac_input_latch_pkg::REF_INTERNAL:
            begin
                internalRef_next = 1'b1;
                refPinInput_next = 1'b0;
            end
            // Bandgap off, reference pin takes an outside voltage
            dac_input_latch_pkg::REF_EXTERNAL:
            begin
                internalRef_next = 1'b0;
                refPinInput_next = 1'b1;
            end
        endcase
    end

    // Register the reference outputs; reset selects the bandgap
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            internalRef_reg <= `INTERNAL_REF_RESET_VALUE;
            refPinInput_reg <= `REF_PIN_INPUT_RESET_VALUE;
        end
        else
        begin
            internalRef_reg <= internalRef_next;
            refPinInput_reg <= refPinInput_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    // Every status output comes straight from its flop
    // No decode sits between the flops and the pins
    assign coreEnable = coreEnable_reg;
    assign standbyActive = standbyActive_reg;
    assign internalRefEnable = internalRef_reg;
    assign referenceVoltagePinIsInput = refPinInput_reg;

endmodule

// *** rtl/sample_stage.sv ***
// Purpose: One clocked stage of the master-slave sample path
// Assumes: Synchronous active-low reset, one clock
// Notes: Holds its word while load is low
`timescale 1ns/10ps
`include "dac_input_latch_consts.svh"

module sample_stage
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic load,
    input wire dac_input_latch_pkg::sample_t dataIn,
    output dac_input_latch_pkg::sample_t dataOut
);

    // Stored word and its next value
    dac_input_latch_pkg::sample_t word_reg;
    dac_input_latch_pkg::sample_t word_next;

    // Next value: load new word or hold
    always_comb
    begin
        word_next = word_reg;
        if (load)
        begin
            word_next = dataIn;
        end
    end

    // Register the word
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            word_reg <= `SAMPLE_RESET_VALUE;
        end
        else
        begin
            word_reg <= word_next;
        end
    end

    assign dataOut = word_reg;

endmodule

// *** verification/dac_input_latch_powerdown_tb.sv ***
// Purpose: Self-checking bench for the input latch
// Assumes: Source model counts through every code
// Notes: A shadow pipeline gives each expected value
`timescale 1ns/10ps
module dac_input_latch_powerdown_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic standbyRequestPin = 1'b0;
    logic standbyRequestPinDriven = 1'b1;
    logic refSelectPin = 1'b0;
    dac_input_latch_pkg::sample_t sampleIn, coreWord, expWord, expMaster;
    logic coreEnable, standbyActive, internalRefEnable;
    logic referenceVoltagePinIsInput, expStby, expRef;
    int miscompares = 0;
    int nChecks = 0;
    // Even duty clock
    always #4 clk = ~clk;
    sample_source u_src (.*);
    dac_input_latch_powerdown u_dut (.*);
    // Shadow pipeline on pre-edge input values
    always @(posedge clk)
    begin
        expStby = nrst & standbyRequestPin & standbyRequestPinDriven;
        expRef = nrst & refSelectPin;
        if (!nrst)
            {expWord, expMaster} = 20'h00000;
        else if (!expStby)
            {expWord, expMaster} = {expMaster, sampleIn};
    end
    task automatic chkWord(input dac_input_latch_pkg::sample_t g, e);
        nChecks++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %0t word %h not %h", $time, g, e);
        end
    endtask
    task automatic chkBit(input logic g, e);
        nChecks++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %0t flag %b not %b", $time, g, e);
        end
    endtask
    // Judge all outputs at each falling edge
    task automatic step(input int n);
        repeat (n)
        begin
            @(negedge clk);
            chkWord(coreWord, expWord);
            chkBit(standbyActive, expStby);
            chkBit(coreEnable, !expStby);
            chkBit(referenceVoltagePinIsInput, expRef);
            chkBit(internalRefEnable, !expRef);
        end
    endtask
    task automatic testStandby;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            standbyRequestPin <= ~i[0];
            step(i == 0 ? 5 : 1);
        end
    endtask
    task automatic testFloat;
        @(posedge clk);
        standbyRequestPinDriven <= 1'b0;
        standbyRequestPin <= 1'b1;
        step(3);
        @(posedge clk);
        standbyRequestPinDriven <= 1'b1;
        step(2);
        @(posedge clk);
        standbyRequestPin <= 1'b0;
        step(3);
    endtask
    task automatic testRef;
        @(posedge clk);
        refSelectPin <= 1'b1;
        step(3);
        @(posedge clk);
        refSelectPin <= 1'b0;
        step(3);
    endtask
    task automatic testReset;
        @(posedge clk);
        nrst <= 1'b0;
        step(2);
        @(posedge clk);
        nrst <= 1'b1;
        step(4);
    endtask
    // Release reset, then sweep every code through the pipeline
    task automatic testSweep;
        @(posedge clk);
        nrst <= 1'b1;
        step(1030);
    endtask
    task automatic summarize;
        if (miscompares == 0 && nChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Reset over three edges, then every scenario
    initial
    begin
        step(2);
        testSweep();
        testStandby();
        testFloat();
        testRef();
        testReset();
        summarize();
    end
    // Watchdog, over twice the expected run
    initial
    begin
        #20000;
        miscompares++;
        summarize();
    end
endmodule
bind dac_input_latch_powerdown latch_checker u_chk (.*);

// *** verification/latch_checker_assertions.sv ***
// Purpose: Port assertions for the converter input latch
// Assumes: Bound to the top module from the testbench
// Notes: Standby level is the pin gated by its driven flag
`timescale 1ns/10ps
module latch_checker
(
    input wire logic clk,
    input wire logic nrst,
    input wire dac_input_latch_pkg::sample_t sampleIn,
    input wire logic standbyRequestPin,
    input wire logic standbyRequestPinDriven,
    input wire logic refSelectPin,
    input wire dac_input_latch_pkg::sample_t coreWord,
    input wire logic coreEnable,
    input wire logic standbyActive,
    input wire logic internalRefEnable,
    input wire logic referenceVoltagePinIsInput
);
    // Standby level after the pull-down
    wire logic sl = standbyRequestPin & standbyRequestPinDriven;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_PIPE: assert property (!sl ##1 !sl |=>
        coreWord == $past(sampleIn, 2)) else $error("late word");
    AST_HOLD: assert property (sl |=> $stable(coreWord))
        else $error("word moved in standby");
    AST_STBY: assert property (sl |=> standbyActive && !coreEnable)
        else $error("no standby");
    AST_RUN: assert property (!sl |=> !standbyActive && coreEnable)
        else $error("no run");
    AST_FLOAT: assert property (!standbyRequestPinDriven |=>
        coreEnable) else $error("floating pin stops core");
    AST_EXT: assert property (refSelectPin |=>
        referenceVoltagePinIsInput && !internalRefEnable) else $error("ext");
    AST_INT: assert property (!refSelectPin |=>
        internalRefEnable && !referenceVoltagePinIsInput) else $error("int");
    AST_EXCL: assert property (coreEnable != standbyActive)
        else $error("mode flags agree");
    // Main scenarios
    cover property (sl ##1 !sl);
    cover property (!standbyRequestPinDriven && standbyRequestPin);
    cover property ($rose(refSelectPin));
endmodule

// *** verification/sample_source.sv ***
// Purpose: Sample source counting through every code
// Assumes: Drives on the rising edge like synthesis logic
// Notes: Straight binary, wraps at full scale
`timescale 1ns/10ps
module sample_source
(
    input wire logic clk,
    input wire logic nrst,
    output dac_input_latch_pkg::sample_t sampleIn
);
    // Up counter, bit zero least significant
    always @(posedge clk)
        sampleIn <= nrst ? sampleIn + 10'h001 : 10'h000;
endmodule
